/* table_branch_exec.sv */
// Purpose: Executes byte and halfword table branches, float gating; if-then decodes are accepted with no action
// Assumes: Register file reads are combinational; load answers with ack
// Notes:   One branch in flight; decode held off via ready
`timescale 1ns/10ps
module table_branch_exec (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Decode
  input  wire tbr_pkg::decode_t  dec,
  output logic                   dec_ready,
  // Register file
  output logic [3:0]             rf_base_idx,
  output logic [3:0]             rf_index_idx,
  input  wire logic [31:0]       rf_base_data,
  input  wire logic [31:0]       rf_index_data,
  // Load path
  output tbr_pkg::load_req_t     load_req,
  input  wire logic              load_ack,
  input  wire logic [15:0]       load_data,
  // Floating point unit
  input  wire logic              floating_point_unit_present,
  input  wire logic              floating_point_unit_enabled,
  output logic                   fp_issue,
  output logic                   fp_undefined,
  // Flags and program counter
  input  wire logic [3:0]        flags_in,
  output logic [3:0]             flags_out,
  output logic                   branch_valid,
  output logic [31:0]            branch_target
);

  // ==========================================================
  // Reset synchroniser
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ==========================================================
  // State
  tbr_pkg::state_t    state_r;
  tbr_pkg::state_t    state_nxt;
  logic               rdy_r;
  logic               rdy_nxt;
  tbr_pkg::load_req_t req_r;
  tbr_pkg::load_req_t req_nxt;
  logic [31:0]        next_r;
  logic [31:0]        next_nxt;
  logic               br_r;
  logic               br_nxt;
  logic [31:0]        tgt_r;
  logic [31:0]        tgt_nxt;
  logic               fpi_r;
  logic               fpi_nxt;
  logic               fpu_r;
  logic               fpu_nxt;
  logic [3:0]         flags_r;
  logic [3:0]         flags_nxt;
  logic               take;
  logic               take_branch;
  logic               take_float;
  logic               fpu_usable;
  logic [31:0]        base_addr;
  logic [31:0]        idx_off;
  logic [31:0]        target;

  // ==========================================================
  // Operands
  assign rf_base_idx  = dec.table_base_register;
  assign rf_index_idx = dec.table_index_register;

  always_comb begin
    // Base: PC means address just after the instruction
    if (dec.table_base_register == tbr_pkg::REG_PC) begin
      base_addr = dec.next_addr;
    end else begin
      base_addr = rf_base_data;
    end
    // Halfword tables need the index doubled
    if (dec.op == tbr_pkg::OP_TABLE_BRANCH_HALFWORD) begin
      idx_off = {rf_index_data[30:0], 1'b0};
    end else begin
      idx_off = rf_index_data;
    end
  end

  tbr_offset u_tbr_offset (
    .halfword  (req_r.halfword),
    .load_data (load_data),
    .next_addr (next_r),
    .target    (target)
  );

  // ==========================================================
  // Take decode
  assign take        = dec.valid && rdy_r && (state_r == tbr_pkg::ST_IDLE);
  assign take_float  = take && dec.fp_op;
  assign take_branch = take && !dec.fp_op &&
                       (dec.op == tbr_pkg::OP_TABLE_BRANCH_BYTE ||
                        dec.op == tbr_pkg::OP_TABLE_BRANCH_HALFWORD);
  assign fpu_usable  = floating_point_unit_present && floating_point_unit_enabled;

  // ==========================================================
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    rdy_nxt   = rdy_r;
    case (state_r)
      tbr_pkg::ST_IDLE: begin
        rdy_nxt = 1'b1;
        if (take_branch) begin
          // Operand legality is left to software
          rdy_nxt   = 1'b0;
          state_nxt = tbr_pkg::ST_LOAD;
        end
      end
      tbr_pkg::ST_LOAD: begin
        if (load_ack) begin
          state_nxt = tbr_pkg::ST_DONE;
        end
      end
      default: begin
        rdy_nxt   = 1'b1;
        state_nxt = tbr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= tbr_pkg::ST_IDLE;
      rdy_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rdy_r   <= rdy_nxt;
    end
  end

  // ==========================================================
  // Table load request
  always_comb begin
    req_nxt  = req_r;
    next_nxt = next_r;
    if (take_branch) begin
      req_nxt.valid    = 1'b1;
      req_nxt.halfword = (dec.op == tbr_pkg::OP_TABLE_BRANCH_HALFWORD);
      req_nxt.addr     = base_addr + idx_off;
      next_nxt         = dec.next_addr;
    end else if (state_r == tbr_pkg::ST_LOAD && load_ack) begin
      req_nxt.valid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      req_r  <= '0;
      next_r <= tbr_pkg::PC_RST;
    end else begin
      req_r  <= req_nxt;
      next_r <= next_nxt;
    end
  end

  // ==========================================================
  // Branch result
  always_comb begin
    br_nxt  = 1'b0;
    tgt_nxt = tgt_r;
    if (state_r == tbr_pkg::ST_LOAD && load_ack) begin
      br_nxt  = 1'b1;
      tgt_nxt = target;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      br_r  <= 1'b0;
      tgt_r <= tbr_pkg::PC_RST;
    end else begin
      br_r  <= br_nxt;
      tgt_r <= tgt_nxt;
    end
  end

  // ==========================================================
  // Floating point gating
  always_comb begin
    fpi_nxt = take_float && fpu_usable;
    fpu_nxt = take_float && !fpu_usable;
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      fpi_r <= 1'b0;
      fpu_r <= 1'b0;
    end else begin
      fpi_r <= fpi_nxt;
      fpu_r <= fpu_nxt;
    end
  end

  // ==========================================================
  // Condition flags
  always_comb begin
    flags_nxt = flags_in;
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      flags_r <= tbr_pkg::FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign dec_ready     = rdy_r;
  assign load_req      = req_r;
  assign flags_out     = flags_r;
  assign branch_valid  = br_r;
  assign branch_target = tgt_r;
  assign fp_issue      = fpi_r;
  assign fp_undefined  = fpu_r;

endmodule

/* table_branch_exec_sva.sv */
// Purpose: Port checks for table_branch_exec
// Assumes: Single clock domain
// Notes:   Bound below
`timescale 1ns/10ps
module table_branch_exec_sva (
  // Ports watched
  input wire logic               clk,
  input wire logic               rst_n,
  input wire tbr_pkg::decode_t   dec,
  input wire logic               dec_ready,
  input wire logic [31:0]        rf_base_data,
  input wire logic [31:0]        rf_index_data,
  input wire tbr_pkg::load_req_t load_req,
  input wire logic               load_ack,
  input wire logic [15:0]        load_data,
  input wire logic               floating_point_unit_present,
  input wire logic               floating_point_unit_enabled,
  input wire logic               fp_issue,
  input wire logic               fp_undefined,
  input wire logic [3:0]         flags_in,
  input wire logic [3:0]         flags_out,
  input wire logic               branch_valid,
  input wire logic [31:0]        branch_target
);
  logic        tk;
  logic        ok;
  logic [15:0] ent;
  logic [31:0] base;
  logic [31:0] nxt_r;
  assign tk = dec.valid && dec_ready;
  assign ok = floating_point_unit_present && floating_point_unit_enabled;
  assign ent = load_req.halfword ? load_data : {8'h0, load_data[7:0]};
  assign base = (dec.table_base_register == tbr_pkg::REG_PC) ? dec.next_addr : rf_base_data;
  always_ff @(posedge clk) begin
    if (tk) begin
      nxt_r <= dec.next_addr;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  byte_addr_a: assert property (
    tk && dec.op == tbr_pkg::OP_TABLE_BRANCH_BYTE |=> load_req.valid && load_req.addr == $past(base + rf_index_data))
    else $error("byte address");
  half_addr_a: assert property (
    tk && dec.op == tbr_pkg::OP_TABLE_BRANCH_HALFWORD |=> load_req.addr == $past(base + (rf_index_data << 1)))
    else $error("halfword address");
  byte_target_a: assert property (
    load_req.valid && load_ack && !load_req.halfword |=> branch_valid && branch_target == nxt_r + 2 * $past(ent))
    else $error("byte target");
  half_target_a: assert property (
    load_req.valid && load_ack && load_req.halfword |=> branch_valid && branch_target == nxt_r + 2 * $past(ent))
    else $error("halfword target");
  flags_kept_a: assert property (
    dec_ready |-> flags_out == $past(flags_in)) else $error("flags changed");
  fp_issue_a: assert property (tk && dec.fp_op && ok |=> fp_issue && !fp_undefined)
    else $error("float not issued");
  fp_refuse_a: assert property (tk && dec.fp_op && !ok |=> fp_undefined && !fp_issue)
    else $error("float not refused");
  fp_cause_a: assert property (fp_issue |-> $past(tk && dec.fp_op && ok))
    else $error("float issued unasked");
  cover property (tk && dec.op == tbr_pkg::OP_IF_THEN_BLOCK);
  cover property (fp_undefined);
  cover property (load_ack && load_req.halfword);
endmodule
bind table_branch_exec table_branch_exec_sva u_sva (.clk, .rst_n, .dec, .dec_ready, .rf_base_data,
  .rf_index_data, .load_req, .load_ack, .load_data, .floating_point_unit_present, .floating_point_unit_enabled,
  .fp_issue, .fp_undefined, .flags_in, .flags_out, .branch_valid, .branch_target);

/* tb.sv */
// Purpose: Scenario bench for table_branch_exec
// Assumes: Inputs change 1 ns after clk rises
// Notes:   Partner stalls with lat
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  tbr_pkg::decode_t dec = '0;
  logic [3:0] lat = 4'h0;
  logic [3:0] flags_in = 4'h6;
  logic [1:0] fp_st = 2'h0;
  logic dec_ready, load_ack, fp_issue, fp_undefined, branch_valid;
  logic [3:0] rf_base_idx, rf_index_idx, flags_out;
  logic [31:0] rf_base_data, rf_index_data, branch_target;
  logic [15:0] load_data;
  tbr_pkg::load_req_t load_req;
  int fail_count = 0;
  int checks_done = 0;
  wire [3:0] ev = {fp_issue | fp_undefined, branch_valid, load_req.valid, dec_ready};
  always #20 clk = ~clk;
  table_branch_exec u_table_branch_exec (.clk, .rst_n, .dec, .dec_ready, .rf_base_idx, .rf_index_idx,
    .rf_base_data, .rf_index_data, .load_req, .load_ack, .load_data, .floating_point_unit_present(fp_st[1]),
    .floating_point_unit_enabled(fp_st[0]), .fp_issue, .fp_undefined, .flags_in, .flags_out, .branch_valid,
    .branch_target);
  tbr_mem_model u_tbr_mem_model (.clk, .lat, .rf_base_idx, .rf_index_idx, .rf_base_data, .rf_index_data,
    .load_req, .load_ack, .load_data);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_on(input int k);
    for (int n = 0; n < 40; n++) begin
      if (ev[k] === 1'b1) return;
      @(posedge clk);
      #1;
    end
    fail_count++;
    finish_test();
  endtask
  task automatic go(input tbr_pkg::decode_t d);
    wait_on(0);
    dec = d;
    @(posedge clk);
    #1;
    dec.valid = 1'b0;
  endtask
  task automatic branch(input tbr_pkg::op_t op, input logic [3:0] b, input logic [3:0] ix, input logic [31:0] na);
    logic [31:0] a;
    logic [15:0] e;
    a = (b == 4'hf ? na : {16'h0, b, 12'h100}) + ({24'h0, ix, 4'h3} << (op == tbr_pkg::OP_TABLE_BRANCH_HALFWORD));
    e = a[15:0] ^ 16'h8a5c;
    if (op == tbr_pkg::OP_TABLE_BRANCH_BYTE) e[15:8] = 8'h0;
    go('{1'b1, op, b, ix, 1'b0, na});
    wait_on(1);
    chk("load_addr", a, load_req.addr);
    wait_on(2);
    chk("target", na + {15'h0, e, 1'b0}, branch_target);
    chk("flags", {28'h0, flags_in}, {28'h0, flags_out});
  endtask
  task automatic test_byte();
    branch(tbr_pkg::OP_TABLE_BRANCH_BYTE, 4'h2, 4'h9, 32'h0000_2000);
    $display("test byte done");
  endtask
  task automatic test_half();
    lat = 4'h3;
    branch(tbr_pkg::OP_TABLE_BRANCH_HALFWORD, 4'hf, 4'h7, 32'h0000_4002);
    $display("test half done");
  endtask
  task automatic test_it();
    flags_in = 4'h9;
    go('{1'b1, tbr_pkg::OP_IF_THEN_BLOCK, 4'h0, 4'h0, 1'b0, 32'h0});
    @(posedge clk);
    #1;
    chk("flags_it", {28'h0, flags_in}, {28'h0, flags_out});
    branch(tbr_pkg::OP_TABLE_BRANCH_BYTE, 4'hf, 4'hc, 32'h0000_3000);
    $display("test if-then done");
  endtask
  task automatic test_fp();
    for (int i = 0; i < 4; i++) begin
      fp_st = i[1:0];
      go('{1'b1, tbr_pkg::OP_NONE, 4'h0, 4'h0, 1'b1, 32'h0});
      wait_on(3);
      chk("fp_issue_undef", (i == 3) ? 32'h2 : 32'h1, {30'h0, fp_issue, fp_undefined});
      @(posedge clk);
      #1;
    end
    $display("test float done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    test_byte();
    test_half();
    test_it();
    test_fp();
    finish_test();
  end
endmodule

/* tbr_mem_model.sv */
// Purpose: Register file and table memory
// Assumes: Entry is address xor a pattern
// Notes:   lat stalls each load
`timescale 1ns/10ps
module tbr_mem_model (
  // Controls
  input  wire logic               clk,
  input  wire logic [3:0]         lat,
  // Register file
  input  wire logic [3:0]         rf_base_idx,
  input  wire logic [3:0]         rf_index_idx,
  output logic [31:0]             rf_base_data,
  output logic [31:0]             rf_index_data,
  // Load path
  input  wire tbr_pkg::load_req_t load_req,
  output logic                    load_ack = 1'b0,
  output logic [15:0]             load_data = 16'h0
);
  logic [3:0] wait_r = 4'h0;
  assign rf_base_data = {16'h0, rf_base_idx, 12'h100};
  assign rf_index_data = {24'h0, rf_index_idx, 4'h3};
  always @(posedge clk) begin
    load_ack <= 1'b0;
    load_data <= ~load_data;
    wait_r <= 4'h0;
    if (load_req.valid && !load_ack) begin
      wait_r <= wait_r + 4'h1;
      if (wait_r == lat) begin
        load_ack <= 1'b1;
        load_data <= load_req.addr[15:0] ^ 16'h8a5c;
      end
    end
  end
endmodule

/* tbr_offset.sv */
// Purpose: Converts a fetched table entry into a forward branch target
// Assumes: Entry arrives in the low bits of the load data
// Notes:   Purely combinational
`timescale 1ns/10ps
module tbr_offset (
  // Entry
  input  wire logic        halfword,
  input  wire logic [15:0] load_data,
  // Base
  input  wire logic [31:0] next_addr,
  // Result
  output logic [31:0] target
);
  logic [31:0] entry;

  always_comb begin
    if (halfword) begin
      entry = {16'h0000, load_data};
    end else begin
      entry = {24'h000000, load_data[7:0]};
    end
    target = next_addr + {entry[30:0], 1'b0};
  end
endmodule

/* tbr_pkg.sv */
// Purpose: Shared constants and types for the table-branch execution block
// Assumes: 32-bit addresses, 16-bit instruction encodings for table branches
package tbr_pkg;

  // ==========================================================
  // Constants
  localparam int        ADDR_W        = 32;
  localparam int        REG_IDX_W     = 4;
  localparam logic [3:0] REG_SP       = 4'hd;
  localparam logic [3:0] REG_PC       = 4'hf;
  localparam logic [31:0] PC_RST      = 32'h0000_0000;
  localparam logic [3:0] FLAGS_RST    = 4'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    OP_NONE                  = 2'b00,
    OP_TABLE_BRANCH_BYTE     = 2'b01,
    OP_TABLE_BRANCH_HALFWORD = 2'b10,
    OP_IF_THEN_BLOCK         = 2'b11
  } op_t;

  typedef struct packed {
    logic        valid;
    op_t         op;
    logic [3:0]  table_base_register;
    logic [3:0]  table_index_register;
    logic        fp_op;
    logic [31:0] next_addr;
  } decode_t;

  typedef struct packed {
    logic        valid;
    logic        halfword;
    logic [31:0] addr;
  } load_req_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOAD  = 2'b01,
    ST_DONE  = 2'b10
  } state_t;

endpackage
